// file: rtl/mbse_consts.svh
// Register offsets, field positions, reset values and cycle counts.
`ifndef MBSE_CONSTS_SVH
`define MBSE_CONSTS_SVH

`define MBSE_OFF_CTRL      6'h00
`define MBSE_OFF_OPCODE    6'h04
`define MBSE_OFF_OPERAND   6'h08
`define MBSE_OFF_POINTER   6'h0C
`define MBSE_OFF_OFFSET    6'h10
`define MBSE_OFF_PC        6'h14
`define MBSE_OFF_STATUS    6'h18
`define MBSE_OFF_PRODUCT   6'h1C
`define MBSE_OFF_CYCLES    6'h20

`define MBSE_CTRL_START    0
`define MBSE_CTRL_BUSY     0
`define MBSE_CTRL_ILLEGAL  1
`define MBSE_OPC_CODE_LSB  0
`define MBSE_OPC_BIT_LSB   8
`define MBSE_OPC_TWO_WORD  16
`define MBSE_OPR_RR_LSB    8

`define MBSE_SR_C 0
`define MBSE_SR_Z 1
`define MBSE_SR_N 2
`define MBSE_SR_V 3
`define MBSE_SR_S 4
`define MBSE_SR_H 5
`define MBSE_SR_T 6
`define MBSE_SR_I 7

`define MBSE_PC_RST    16'h0000
`define MBSE_STATUS_REGISTER_RST  8'h00

`define MBSE_CYC_TST       3'h1
`define MBSE_CYC_CPI       3'h1
`define MBSE_CYC_MUL       3'h2
`define MBSE_CYC_INDIRECT_JUMP      3'h2
`define MBSE_CYC_RELATIVE_CALL     3'h4
`define MBSE_CYC_INDIRECT_CALL     3'h4
`define MBSE_CYC_CALL      3'h5
`define MBSE_CYC_NO_SKIP   3'h1
`define MBSE_CYC_SKIP_ONE  3'h2
`define MBSE_CYC_SKIP_TWO  3'h3
`define MBSE_CYC_BR_NOT    3'h1
`define MBSE_CYC_BR_TAKEN  3'h2

`endif

// file: rtl/mbse_pkg.sv
// Types shared by the execution unit and its helpers.
package mbse_pkg;

  typedef enum logic [4:0] {
    MBSE_OP_TST    = 5'h00, MBSE_OP_MUL    = 5'h01, MBSE_OP_MULT_SIGNED   = 5'h02,
    MBSE_OP_MULT_SIGNED_BY_UNSIGNED  = 5'h03, MBSE_OP_FRAC_MULT_UNSIGNED   = 5'h04, MBSE_OP_FRAC_MULT_SIGNED  = 5'h05,
    MBSE_OP_FRAC_MULT_SIGNED_BY_UNSIGNED = 5'h06, MBSE_OP_INDIRECT_JUMP   = 5'h07, MBSE_OP_RELATIVE_CALL  = 5'h08,
    MBSE_OP_INDIRECT_CALL  = 5'h09, MBSE_OP_CALL   = 5'h0A, MBSE_OP_COMPARE_SKIP_EQUAL   = 5'h0B,
    MBSE_OP_CPI    = 5'h0C, MBSE_OP_SRC    = 5'h0D, MBSE_OP_SRS    = 5'h0E,
    MBSE_OP_SIC    = 5'h0F, MBSE_OP_SIS    = 5'h10, MBSE_OP_BRANCH_STATUS_SET   = 5'h11,
    MBSE_OP_BRANCH_STATUS_CLEAR   = 5'h12, MBSE_OP_BRANCH_SIGNED_GE   = 5'h13, MBSE_OP_BRANCH_SIGNED_LT   = 5'h14,
    MBSE_OP_BRANCH_SAME_HIGHER   = 5'h15, MBSE_OP_BRANCH_LOWER   = 5'h16, MBSE_OP_BRANCH_HALFCARRY_SET   = 5'h17,
    MBSE_OP_BRANCH_HALFCARRY_CLEAR   = 5'h18, MBSE_OP_BRANCH_TRANSFER_SET   = 5'h19, MBSE_OP_BRTC   = 5'h1A
  } mbse_op_e;

  typedef enum logic [1:0] {
    MBSE_MM_UU = 2'b00,
    MBSE_MM_SS = 2'b01,
    MBSE_MM_SU = 2'b10
  } mbse_mmode_e;

  typedef enum logic [0:0] {
    MBSE_IDLE = 1'b0,
    MBSE_EXEC = 1'b1
  } mbse_fsm_e;

  typedef struct packed {
    mbse_fsm_e   state;
    logic [2:0]  left;
    logic [2:0]  cycles;
    logic        illegal;
    mbse_op_e    op;
    logic [2:0]  bsel;
    logic        two_word;
    logic [7:0]  rd;
    logic [7:0]  rr;
    logic [15:0] zptr;
    logic [15:0] koff;
    logic [15:0] pc;
    logic [7:0]  status_register;
    logic [15:0] prod;
    logic        rd_pend;
    logic [31:0] rdata;
  } mbse_state_s;

endpackage : mbse_pkg

// file: rtl/mbse_mult.sv
// Two-operand 8x8 multiplier with signed, mixed and fractional forms.
`timescale 1ns/10ps
module mbse_mult
  import mbse_pkg::*;
(
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  input  wire mbse_mmode_e mode,
  input  wire logic        frac,
  output logic      [15:0] product,
  output logic             zero,
  output logic             carry
);

  logic signed [8:0]  a_ext;
  logic signed [8:0]  b_ext;
  logic signed [17:0] full;
  logic        [15:0] raw;

  always_comb begin
    a_ext   = {(mode != MBSE_MM_UU) & a[7], a};
    b_ext   = {(mode == MBSE_MM_SS) & b[7], b};
    full    = a_ext * b_ext;
    raw     = full[15:0];
    // Carry is the top bit of the product before the fractional shift.
    carry   = raw[15];
    product = frac ? {raw[14:0], 1'b0} : raw;
    zero    = (product == 16'h0000);
  end

endmodule : mbse_mult

// file: rtl/mbse_cond.sv
// Skip and branch condition evaluation plus test and compare flags.
`timescale 1ns/10ps
`include "mbse_consts.svh"
module mbse_cond
  import mbse_pkg::*;
(
  input  wire mbse_op_e   op,
  input  wire logic [2:0] bsel,
  input  wire logic [7:0] rd,
  input  wire logic [7:0] rr,
  input  wire logic [7:0] status_register,
  output logic            hit,
  output logic      [7:0] status_register_tst,
  output logic      [7:0] status_register_cpi
);

  function automatic logic bit_at(input logic [7:0] v, input logic [2:0] b);
    bit_at = v[b];
  endfunction : bit_at

  logic [7:0] diff;
  logic       n_x_v;

  always_comb begin
    n_x_v = status_register[`MBSE_SR_N] ^ status_register[`MBSE_SR_V];
    case (op)
      MBSE_OP_COMPARE_SKIP_EQUAL: hit = (rd == rr);
      MBSE_OP_SRC:  hit = !bit_at(rd, bsel);
      MBSE_OP_SRS:  hit = bit_at(rd, bsel);
      MBSE_OP_SIC:  hit = !bit_at(rr, bsel);
      MBSE_OP_SIS:  hit = bit_at(rr, bsel);
      MBSE_OP_BRANCH_STATUS_SET: hit = bit_at(status_register, bsel);
      MBSE_OP_BRANCH_STATUS_CLEAR: hit = !bit_at(status_register, bsel);
      MBSE_OP_BRANCH_SIGNED_GE: hit = !n_x_v;
      MBSE_OP_BRANCH_SIGNED_LT: hit = n_x_v;
      MBSE_OP_BRANCH_SAME_HIGHER: hit = !status_register[`MBSE_SR_C];
      MBSE_OP_BRANCH_LOWER: hit = status_register[`MBSE_SR_C];
      MBSE_OP_BRANCH_HALFCARRY_SET: hit = status_register[`MBSE_SR_H];
      MBSE_OP_BRANCH_HALFCARRY_CLEAR: hit = !status_register[`MBSE_SR_H];
      MBSE_OP_BRANCH_TRANSFER_SET: hit = status_register[`MBSE_SR_T];
      MBSE_OP_BRTC: hit = !status_register[`MBSE_SR_T];
      default:      hit = 1'b0;
    endcase
    status_register_tst                = status_register;
    status_register_tst[`MBSE_SR_Z]    = (rd == 8'h00);
    status_register_tst[`MBSE_SR_N]    = rd[7];
    status_register_tst[`MBSE_SR_V]    = 1'b0;
    diff                    = rd - rr;
    status_register_cpi                = status_register;
    status_register_cpi[`MBSE_SR_Z]    = (diff == 8'h00);
    status_register_cpi[`MBSE_SR_N]    = diff[7];
    status_register_cpi[`MBSE_SR_V]    = (rd[7] & ~rr[7] & ~diff[7])
                            | (~rd[7] & rr[7] & diff[7]);
    status_register_cpi[`MBSE_SR_C]    = (~rd[7] & rr[7]) | (rr[7] & diff[7])
                            | (diff[7] & ~rd[7]);
    status_register_cpi[`MBSE_SR_H]    = (~rd[3] & rr[3]) | (rr[3] & diff[3])
                            | (diff[3] & ~rd[3]);
  end

endmodule : mbse_cond

// file: rtl/mbse_exec.sv
// Execution unit for test, multiply, call, skip and branch instructions.
//
// How it works
// - Test ANDs a register with itself, sets Z N V only, one cycle.
// - Plain multiplies write 16-bit product pair, update Z C, two cycles.
// - Fractional multiplies shift product left one, update Z C, two cycles.
// - Indirect jump loads PC from pointer pair, flags kept, two cycles.
// - Relative call sets PC to PC plus offset plus one, four cycles.
// - Indirect call loads PC from pointer pair, four cycles, flags kept.
// - Direct call loads PC with absolute address, five cycles.
// - Compare-skip-equal skips next instruction when registers match.
// - Compare immediate subtracts constant, sets Z N V C H, one cycle.
// - Register bit skips test a register bit clear or set.
// - I/O bit skips test an I/O register bit set or clear.
// - Status branches jump by offset plus one on status bit state.
// - Signed branches use N xor V: zero for ge, one for lt.
// - Same-or-higher branches on carry clear, lower on carry set.
// - Half-carry branches jump on H set or clear respectively.
// - Transfer-bit branches jump on T set or clear respectively.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "mbse_consts.svh"
module mbse_exec
  import mbse_pkg::*;
#(
  parameter int ADDR_W = 6
)
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest
);

  generate
    if (ADDR_W < 6) begin : g_bad_addr
      $error("mbse_exec: ADDR_W must be at least 6");
    end
  endgenerate

  localparam mbse_state_s RESET_S = '{state: MBSE_IDLE, op: MBSE_OP_TST,
                                      pc: `MBSE_PC_RST,
                                      status_register: `MBSE_STATUS_REGISTER_RST, default: '0};

  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    be_merge = res;
  endfunction : be_merge

  mbse_state_s s_reg;
  mbse_state_s s_next;

  logic        busy;
  logic        go;
  logic        commit;
  logic        wr_ok;
  logic [5:0]  addr;
  logic [31:0] cur_word;
  logic [31:0] merged;
  logic [15:0] pc_inc;
  logic [15:0] pc_rel;
  logic [15:0] exe_pc;
  logic [7:0]  exe_status_register;
  logic [2:0]  exe_cyc;
  logic        exe_wprod;
  logic        exe_illegal;
  mbse_mmode_e mmode;
  logic        mfrac;
  logic [15:0] m_prod;
  logic        m_zero;
  logic        m_carry;
  logic        c_hit;
  logic [7:0]  c_status_register_tst;
  logic [7:0]  c_status_register_cpi;

  mbse_mult u_mult (
    .a       (s_reg.rd),
    .b       (s_reg.rr),
    .mode    (mmode),
    .frac    (mfrac),
    .product (m_prod),
    .zero    (m_zero),
    .carry   (m_carry)
  );

  mbse_cond u_cond (
    .op       (s_reg.op),
    .bsel     (s_reg.bsel),
    .rd       (s_reg.rd),
    .rr       (s_reg.rr),
    .status_register     (s_reg.status_register),
    .hit      (c_hit),
    .status_register_tst (c_status_register_tst),
    .status_register_cpi (c_status_register_cpi)
  );

  // Bus handshake: reads wait one cycle for registered data, writes stall
  // while an instruction runs so its operands cannot change under it.
  always_comb begin
    busy            = (s_reg.state == MBSE_EXEC);
    addr            = avs_address[5:0];
    avs_waitrequest = (avs_read & ~s_reg.rd_pend) | (avs_write & busy);
    avs_readdata    = s_reg.rdata;
    wr_ok           = avs_write & ~busy;
    go              = wr_ok & (addr == `MBSE_OFF_CTRL)
                    & avs_byteenable[0] & avs_writedata[`MBSE_CTRL_START];
    commit          = busy & (s_reg.left == 3'h0);
  end

  // Readback word for the addressed register, also the base of merges.
  always_comb begin
    cur_word = 32'h0000_0000;
    case (addr)
      `MBSE_OFF_CTRL: begin
        cur_word[`MBSE_CTRL_BUSY]    = busy;
        cur_word[`MBSE_CTRL_ILLEGAL] = s_reg.illegal;
      end
      `MBSE_OFF_OPCODE: begin
        cur_word[`MBSE_OPC_CODE_LSB +: 5] = s_reg.op;
        cur_word[`MBSE_OPC_BIT_LSB +: 3]  = s_reg.bsel;
        cur_word[`MBSE_OPC_TWO_WORD]      = s_reg.two_word;
      end
      `MBSE_OFF_OPERAND: cur_word[15:0] = {s_reg.rr, s_reg.rd};
      `MBSE_OFF_POINTER: cur_word[15:0] = s_reg.zptr;
      `MBSE_OFF_OFFSET:  cur_word[15:0] = s_reg.koff;
      `MBSE_OFF_PC:      cur_word[15:0] = s_reg.pc;
      `MBSE_OFF_STATUS:  cur_word[7:0]  = s_reg.status_register;
      `MBSE_OFF_PRODUCT: cur_word[15:0] = s_reg.prod;
      `MBSE_OFF_CYCLES:  cur_word[2:0]  = s_reg.cycles;
      default:           cur_word = 32'h0000_0000;
    endcase
    merged = be_merge(cur_word, avs_writedata, avs_byteenable);
  end

  // Outcome of the loaded instruction: next PC, flags and cycle count.
  always_comb begin
    pc_inc      = s_reg.pc + 16'h0001;
    pc_rel      = s_reg.pc + s_reg.koff + 16'h0001;
    exe_pc      = pc_inc;
    exe_status_register    = s_reg.status_register;
    exe_cyc     = `MBSE_CYC_TST;
    exe_wprod   = 1'b0;
    exe_illegal = 1'b0;
    mfrac       = (s_reg.op == MBSE_OP_FRAC_MULT_UNSIGNED) | (s_reg.op == MBSE_OP_FRAC_MULT_SIGNED)
                | (s_reg.op == MBSE_OP_FRAC_MULT_SIGNED_BY_UNSIGNED);
    if ((s_reg.op == MBSE_OP_MULT_SIGNED) | (s_reg.op == MBSE_OP_FRAC_MULT_SIGNED)) begin
      mmode = MBSE_MM_SS;
    end else if ((s_reg.op == MBSE_OP_MULT_SIGNED_BY_UNSIGNED)
                 | (s_reg.op == MBSE_OP_FRAC_MULT_SIGNED_BY_UNSIGNED)) begin
      mmode = MBSE_MM_SU;
    end else begin
      mmode = MBSE_MM_UU;
    end
    case (s_reg.op)
      MBSE_OP_TST: begin
        exe_status_register = c_status_register_tst;
        exe_cyc  = `MBSE_CYC_TST;
      end
      MBSE_OP_MUL, MBSE_OP_MULT_SIGNED, MBSE_OP_MULT_SIGNED_BY_UNSIGNED,
      MBSE_OP_FRAC_MULT_UNSIGNED, MBSE_OP_FRAC_MULT_SIGNED, MBSE_OP_FRAC_MULT_SIGNED_BY_UNSIGNED: begin
        exe_wprod           = 1'b1;
        exe_status_register[`MBSE_SR_Z] = m_zero;
        exe_status_register[`MBSE_SR_C] = m_carry;
        exe_cyc             = `MBSE_CYC_MUL;
      end
      MBSE_OP_INDIRECT_JUMP: begin
        exe_pc  = s_reg.zptr;
        exe_cyc = `MBSE_CYC_INDIRECT_JUMP;
      end
      MBSE_OP_RELATIVE_CALL: begin
        exe_pc  = pc_rel;
        exe_cyc = `MBSE_CYC_RELATIVE_CALL;
      end
      MBSE_OP_INDIRECT_CALL: begin
        exe_pc  = s_reg.zptr;
        exe_cyc = `MBSE_CYC_INDIRECT_CALL;
      end
      MBSE_OP_CALL: begin
        exe_pc  = s_reg.koff;
        exe_cyc = `MBSE_CYC_CALL;
      end
      MBSE_OP_COMPARE_SKIP_EQUAL, MBSE_OP_SRC, MBSE_OP_SRS, MBSE_OP_SIC,
      MBSE_OP_SIS: begin
        if (!c_hit) begin
          exe_cyc = `MBSE_CYC_NO_SKIP;
        end else if (s_reg.two_word) begin
          exe_pc  = s_reg.pc + 16'h0003;
          exe_cyc = `MBSE_CYC_SKIP_TWO;
        end else begin
          exe_pc  = s_reg.pc + 16'h0002;
          exe_cyc = `MBSE_CYC_SKIP_ONE;
        end
      end
      MBSE_OP_CPI: begin
        exe_status_register = c_status_register_cpi;
        exe_cyc  = `MBSE_CYC_CPI;
      end
      MBSE_OP_BRANCH_STATUS_SET, MBSE_OP_BRANCH_STATUS_CLEAR, MBSE_OP_BRANCH_SIGNED_GE, MBSE_OP_BRANCH_SIGNED_LT,
      MBSE_OP_BRANCH_SAME_HIGHER, MBSE_OP_BRANCH_LOWER, MBSE_OP_BRANCH_HALFCARRY_SET, MBSE_OP_BRANCH_HALFCARRY_CLEAR,
      MBSE_OP_BRANCH_TRANSFER_SET, MBSE_OP_BRTC: begin
        if (c_hit) begin
          exe_pc  = pc_rel;
          exe_cyc = `MBSE_CYC_BR_TAKEN;
        end else begin
          exe_cyc = `MBSE_CYC_BR_NOT;
        end
      end
      default: begin
        exe_illegal = 1'b1;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    if (avs_read & ~s_reg.rd_pend) begin
      s_next.rdata   = cur_word;
      s_next.rd_pend = 1'b1;
    end else begin
      s_next.rd_pend = 1'b0;
    end
    if (wr_ok) begin
      case (addr)
        `MBSE_OFF_OPCODE: begin
          s_next.op       = mbse_op_e'(merged[`MBSE_OPC_CODE_LSB +: 5]);
          s_next.bsel     = merged[`MBSE_OPC_BIT_LSB +: 3];
          s_next.two_word = merged[`MBSE_OPC_TWO_WORD];
        end
        `MBSE_OFF_OPERAND: {s_next.rr, s_next.rd} = merged[15:0];
        `MBSE_OFF_POINTER: s_next.zptr = merged[15:0];
        `MBSE_OFF_OFFSET:  s_next.koff = merged[15:0];
        `MBSE_OFF_PC:      s_next.pc   = merged[15:0];
        `MBSE_OFF_STATUS:  s_next.status_register = merged[7:0];
        default: begin
        end
      endcase
    end
    case (s_reg.state)
      MBSE_IDLE: begin
        if (go) begin
          s_next.state   = MBSE_EXEC;
          s_next.left    = 3'(exe_cyc - 3'h1);
          s_next.cycles  = exe_cyc;
          s_next.illegal = exe_illegal;
        end
      end
      MBSE_EXEC: begin
        if (commit) begin
          s_next.state = MBSE_IDLE;
          s_next.pc    = exe_pc;
          s_next.status_register  = exe_status_register;
          if (exe_wprod) begin
            s_next.prod = m_prod;
          end
        end else begin
          s_next.left = 3'(s_reg.left - 3'h1);
        end
      end
      default: s_next.state = MBSE_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= RESET_S;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence run1; busy ##1 !busy; endsequence
  sequence run2; busy[*2] ##1 !busy; endsequence
  sequence run3; busy[*3] ##1 !busy; endsequence
  sequence run4; busy[*4] ##1 !busy; endsequence
  sequence run5; busy[*5] ##1 !busy; endsequence

  logic [7:0] sr;
  assign sr = s_reg.status_register;

  tst_flags_a: assert property (go && s_reg.op == MBSE_OP_TST |=> run1 ##0
    (sr[`MBSE_SR_Z] == (s_reg.rd == 8'h00) && sr[`MBSE_SR_N] == s_reg.rd[7]
     && !sr[`MBSE_SR_V] && sr[`MBSE_SR_C] == $past(sr[`MBSE_SR_C])))
    else $error("test flags wrong");
  mul_product_a: assert property (go && s_reg.op == MBSE_OP_MULT_SIGNED |=> run2 ##0
    (s_reg.prod == 16'($signed(s_reg.rd) * $signed(s_reg.rr))
     && sr[`MBSE_SR_Z] == (s_reg.prod == 16'h0000)))
    else $error("signed multiply result wrong");
  frac_product_a: assert property (go && s_reg.op == MBSE_OP_FRAC_MULT_UNSIGNED |=> run2
    ##0 (s_reg.prod == 16'({8'h00, s_reg.rd} * {8'h00, s_reg.rr} << 1)
     && sr[`MBSE_SR_C] == 16'({8'h00, s_reg.rd} * {8'h00, s_reg.rr}) >> 15))
    else $error("fractional multiply result wrong");
  indirect_jump_target_a: assert property (go && s_reg.op == MBSE_OP_INDIRECT_JUMP |=> run2
    ##0 (s_reg.pc == s_reg.zptr && sr == $past(sr)))
    else $error("indirect jump wrong");
  relative_call_target_a: assert property (go && s_reg.op == MBSE_OP_RELATIVE_CALL |=> run4
    ##0 (s_reg.pc == 16'($past(s_reg.pc) + s_reg.koff + 16'h0001)))
    else $error("relative call wrong");
  indirect_call_target_a: assert property (go && s_reg.op == MBSE_OP_INDIRECT_CALL |=> run4
    ##0 (s_reg.pc == s_reg.zptr && sr == $past(sr)))
    else $error("indirect call wrong");
  call_target_a: assert property (go && s_reg.op == MBSE_OP_CALL |=> run5
    ##0 (s_reg.pc == s_reg.koff && sr == $past(sr)))
    else $error("direct call wrong");
  compare_skip_equal_skip_a: assert property (go && s_reg.op == MBSE_OP_COMPARE_SKIP_EQUAL
    && s_reg.rd == s_reg.rr && !s_reg.two_word |=> run2
    ##0 (s_reg.pc == 16'($past(s_reg.pc) + 16'h0002)))
    else $error("compare skip wrong");
  cpi_flags_a: assert property (go && s_reg.op == MBSE_OP_CPI |=> run1 ##0
    (sr[`MBSE_SR_C] == (s_reg.rd < s_reg.rr)
     && sr[`MBSE_SR_Z] == (s_reg.rd == s_reg.rr)))
    else $error("compare immediate flags wrong");
  skip_reg_bit_clear_skip_a: assert property (go && s_reg.op == MBSE_OP_SRC
    && !s_reg.rd[s_reg.bsel] && s_reg.two_word |=> run3
    ##0 (s_reg.pc == 16'($past(s_reg.pc) + 16'h0003)))
    else $error("register bit skip wrong");
  skip_io_bit_set_skip_a: assert property (go && s_reg.op == MBSE_OP_SIS
    && s_reg.rr[s_reg.bsel] && !s_reg.two_word |=> run2
    ##0 (s_reg.pc == 16'($past(s_reg.pc) + 16'h0002)))
    else $error("io bit skip wrong");
  branch_status_set_taken_a: assert property (go && s_reg.op == MBSE_OP_BRANCH_STATUS_SET
    && sr[s_reg.bsel] |=> run2
    ##0 (s_reg.pc == 16'($past(s_reg.pc) + s_reg.koff + 16'h0001)))
    else $error("status branch wrong");
  branch_signed_ge_taken_a: assert property (go && s_reg.op == MBSE_OP_BRANCH_SIGNED_GE
    && sr[`MBSE_SR_N] == sr[`MBSE_SR_V] |=> run2)
    else $error("signed branch wrong");
  branch_lower_taken_a: assert property (go && s_reg.op == MBSE_OP_BRANCH_LOWER
    && sr[`MBSE_SR_C] |=> run2)
    else $error("lower branch wrong");
  branch_halfcarry_set_idle_a: assert property (go && s_reg.op == MBSE_OP_BRANCH_HALFCARRY_SET
    && !sr[`MBSE_SR_H] |=> run1)
    else $error("half carry branch wrong");
  branch_transfer_set_taken_a: assert property (go && s_reg.op == MBSE_OP_BRANCH_TRANSFER_SET
    && sr[`MBSE_SR_T] |=> run2)
    else $error("transfer branch wrong");
  skip_none_a: assert property (go && s_reg.op == MBSE_OP_SRS
    && !s_reg.rd[s_reg.bsel] |=> run1
    ##0 (s_reg.pc == 16'($past(s_reg.pc) + 16'h0001)))
    else $error("unskipped skip wrong");
  br_not_taken_a: assert property (go && s_reg.op == MBSE_OP_BRANCH_STATUS_CLEAR
    && sr[s_reg.bsel] |=> run1
    ##0 (s_reg.pc == 16'($past(s_reg.pc) + 16'h0001)))
    else $error("untaken branch wrong");

endmodule : mbse_exec

// file: dv/mbse_exec_tb_top.sv
// Self-checking testbench for the execution unit over its register bus.
`timescale 1ns/10ps
`include "mbse_consts.svh"
module mbse_exec_tb_top
  import mbse_pkg::*;
;
  logic        clk = 0;
  logic        reset = 1;
  logic [5:0]  avs_address = 0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cyc = 0;

  mbse_exec uut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  initial forever #12.5 clk = ~clk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; the request is held until the edge at
  // which waitrequest is low, then released with one idle edge after it.
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask : bus

  task automatic ex(input logic [4:0] op, input logic [2:0] b,
      input logic tw, input logic [15:0] opr, z, k, pc, input logic [7:0] sr,
      input logic [15:0] epc, input logic [7:0] esr, input logic [2:0] en);
    logic [31:0] q;
    bus(1, `MBSE_OFF_OPCODE, {15'h0, tw, 5'h0, b, 3'h0, op}, q);
    bus(1, `MBSE_OFF_OPERAND, {16'h0, opr}, q);
    bus(1, `MBSE_OFF_POINTER, {16'h0, z}, q);
    bus(1, `MBSE_OFF_OFFSET, {16'h0, k}, q);
    bus(1, `MBSE_OFF_PC, {16'h0, pc}, q);
    bus(1, `MBSE_OFF_STATUS, {24'h0, sr}, q);
    bus(1, `MBSE_OFF_CTRL, 32'h0000_0001, q);
    do bus(0, `MBSE_OFF_CTRL, 0, q); while (q[0] !== 1'b0);
    bus(0, `MBSE_OFF_PC, 0, q);
    chk(q, {16'h0, epc});
    bus(0, `MBSE_OFF_STATUS, 0, q);
    chk(q, {24'h0, esr});
    bus(0, `MBSE_OFF_CYCLES, 0, q);
    chk(q, {29'h0, en});
  endtask : ex

  task automatic mm(input logic [4:0] op, input logic [15:0] opr,
      input logic [15:0] ep, input logic [7:0] esr);
    logic [31:0] q;
    ex(op, 0, 0, opr, 0, 0, 16'h0007, 8'hFE, 16'h0008, esr, 2);
    bus(0, `MBSE_OFF_PRODUCT, 0, q);
    chk(q, {16'h0, ep});
  endtask : mm

  task automatic t_reset;
    logic [31:0] q;
    bus(0, `MBSE_OFF_PC, 0, q);
    chk(q, 32'h0000_0000);
    bus(0, `MBSE_OFF_STATUS, 0, q);
    chk(q, 32'h0000_0000);
    bus(0, 6'h24, 0, q);
    chk(q, 32'h0000_0000);
  endtask : t_reset

  task automatic t_tst_cpi;
    ex(0, 0, 0, 16'h0080, 0, 0, 16'h0001, 8'h18, 16'h0002, 8'h14, 1);
    ex(0, 0, 0, 16'h0000, 0, 0, 16'h0001, 8'h04, 16'h0002, 8'h02, 1);
    ex(12, 0, 0, 16'h2010, 0, 0, 16'h0003, 8'h00, 16'h0004, 8'h05, 1);
    ex(12, 0, 0, 16'h0180, 0, 0, 16'h0003, 8'h00, 16'h0004, 8'h28, 1);
    ex(12, 0, 0, 16'h3333, 0, 0, 16'h0003, 8'h15, 16'h0004, 8'h12, 1);
  endtask : t_tst_cpi

  task automatic t_mul;
    mm(1, 16'hFFFF, 16'hFE01, 8'hFD);
    mm(1, 16'h1200, 16'h0000, 8'hFE);
    mm(2, 16'h8080, 16'h4000, 8'hFC);
    mm(3, 16'h02FF, 16'hFFFE, 8'hFD);
    mm(4, 16'h8080, 16'h8000, 8'hFC);
    mm(5, 16'h8080, 16'h8000, 8'hFC);
    mm(6, 16'h80FF, 16'hFF00, 8'hFD);
  endtask : t_mul

  task automatic t_flow;
    ex(7, 0, 0, 0, 16'h1234, 0, 16'h0100, 8'hA5, 16'h1234, 8'hA5, 2);
    ex(8, 0, 0, 0, 0, 16'hFFF0, 16'h0100, 8'hA5, 16'h00F1, 8'hA5, 4);
    ex(9, 0, 0, 0, 16'hBEEF, 0, 16'h0100, 8'hA5, 16'hBEEF, 8'hA5, 4);
    ex(10, 0, 0, 0, 0, 16'hABCD, 16'h0100, 8'hA5, 16'hABCD, 8'hA5, 5);
  endtask : t_flow

  task automatic t_skip;
    ex(11, 0, 1, 16'h5555, 0, 0, 16'h0040, 8'h5A, 16'h0043, 8'h5A, 3);
    ex(11, 0, 0, 16'h5455, 0, 0, 16'h0040, 8'h5A, 16'h0041, 8'h5A, 1);
    ex(11, 0, 0, 16'h5555, 0, 0, 16'h0040, 8'h5A, 16'h0042, 8'h5A, 2);
    ex(13, 3, 0, 16'hF7F7, 0, 0, 16'h0040, 8'h5A, 16'h0042, 8'h5A, 2);
    ex(13, 3, 1, 16'hF7F7, 0, 0, 16'h0040, 8'h5A, 16'h0043, 8'h5A, 3);
    ex(14, 3, 0, 16'hF7F7, 0, 0, 16'h0040, 8'h5A, 16'h0041, 8'h5A, 1);
    ex(14, 3, 1, 16'h0808, 0, 0, 16'h0040, 8'h5A, 16'h0043, 8'h5A, 3);
    ex(15, 3, 1, 16'hF7F7, 0, 0, 16'h0040, 8'h5A, 16'h0043, 8'h5A, 3);
    ex(16, 3, 0, 16'hF7F7, 0, 0, 16'h0040, 8'h5A, 16'h0041, 8'h5A, 1);
    ex(16, 3, 0, 16'h0808, 0, 0, 16'h0040, 8'h5A, 16'h0042, 8'h5A, 2);
  endtask : t_skip

  task automatic t_branch;
    logic [4:0] o[12] = '{19, 19, 20, 20, 21, 21, 22, 22, 23, 24, 25, 26};
    logic [7:0] s[12] = '{8'h0C, 8'h04, 8'h0C, 8'h04, 8'h00, 8'h01,
                          8'h00, 8'h01, 8'h20, 8'h20, 8'h40, 8'h40};
    bit t[12] = '{1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0};
    for (int i = 0; i < 8; i++) begin
      ex(17, i, 0, 0, 0, 16'hFFFB, 16'h0010, 8'h01 << i, 16'h000C,
         8'h01 << i, 2);
      ex(18, i, 0, 0, 0, 16'hFFFB, 16'h0010, 8'h01 << i, 16'h0011,
         8'h01 << i, 1);
    end
    ex(23, 0, 0, 0, 0, 16'hFFFB, 16'h0010, 8'h00, 16'h0011, 8'h00, 1);
    for (int i = 0; i < 12; i++) begin
      ex(o[i], 0, 0, 0, 0, 16'hFFFB, 16'h0010, s[i],
         t[i] ? 16'h000C : 16'h0011, s[i], t[i] ? 2 : 1);
    end
  endtask : t_branch

  // A write issued during a call stalls and lands after the call's result.
  task automatic t_bus;
    logic [31:0] q;
    ex(10, 0, 0, 0, 0, 16'h0200, 16'h0001, 8'h00, 16'h0200, 8'h00, 5);
    bus(1, `MBSE_OFF_CTRL, 32'h0000_0001, q);
    bus(1, `MBSE_OFF_PC, 32'h0000_5555, q);
    bus(0, `MBSE_OFF_PC, 0, q);
    chk(q, 32'h0000_5555);
    bus(1, `MBSE_OFF_PRODUCT, 32'h0000_1111, q);
    bus(0, `MBSE_OFF_PRODUCT, 0, q);
    chk(q, 32'h0000_FF00);
    ex(5'h1F, 0, 0, 0, 0, 0, 16'h0009, 8'h00, 16'h000A, 8'h00, 1);
    bus(0, `MBSE_OFF_CTRL, 0, q);
    chk(q, 32'h0000_0002);
  endtask : t_bus

  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    t_reset();
    t_tst_cpi();
    t_mul();
    t_flow();
    t_skip();
    t_branch();
    t_bus();
    summarize();
  end
endmodule : mbse_exec_tb_top
